// *** design/feic_ctrl.sv ***
// Module: flash erase and write interlock controller with APB registers
// Functional notes
// RULE1: Program bank control bit 11 shows busy
// RULE2: Data flash control bit 11 shows busy
// RULE3: Bit 9 erases page chosen by bits 4:0
// RULE4: Page erase bit self-clears on completion
// RULE5: Bit 8 mass-erases bank, self-clears when done
// RULE6: Data flash bit 8 mass-erases, self-clears
// RULE7: Data flash page selector is bits 5:0
// RULE8: Software loads key A for bank 1/data
// RULE9: Software loads key B for bank 2
// RULE10: No cycle starts without matching key
// RULE11: Key register clears when cycle completes
// RULE12: Software writes zero to reserved bit 10
// RULE13: Erase bits and page selector reset zero
// RULE14: Busy held for the whole cycle
`timescale 1ns/1ns
module feic_ctrl
    import feic_pkg::*;
(
    input  wire logic                       I_CLOCK,
    input  wire logic                       I_RST_N,
    input  wire logic                       I_PSEL,
    input  wire logic                       I_PENABLE,
    input  wire logic                       I_PWRITE,
    input  wire logic [31:0]                I_PADDR,
    input  wire logic [31:0]                I_PWDATA,
    output logic      [31:0]                O_PRDATA,
    output logic                            O_PREADY,
    output logic                            O_PSLVERR,
    input  wire logic [FEIC_NARR-1:0]       I_WRITE_REQ,
    input  wire logic [FEIC_NARR-1:0]       I_FLASH_DONE,
    output feic_cmd_s [FEIC_NARR-1:0]       O_FLASH_CMD,
    output logic      [FEIC_NARR-1:0]       O_BUSY,
    output logic                            O_IRQ
);

    // ==================================================================
    // Control word packing
    // ==================================================================
    function automatic logic [31:0] ctl_word(input logic b, input logic pe, input logic me,
                                             input logic [FEIC_PSEL_W-1:0] ps);
        logic [31:0] w;
        w                   = '0;
        w[FEIC_BUSY_BIT]    = b;
        w[FEIC_PE_BIT]      = pe;
        w[FEIC_ME_BIT]      = me;
        w[FEIC_PSEL_W-1:0]  = ps;
        return w;
    endfunction

    // ==================================================================
    // State
    // ==================================================================
    feic_state_e                st_q     [FEIC_NARR];
    feic_state_e                st_d     [FEIC_NARR];
    logic [FEIC_PSEL_W-1:0]     psel_q   [FEIC_NARR];
    logic [FEIC_PSEL_W-1:0]     psel_d   [FEIC_NARR];
    logic [31:0]                ctl_rd   [FEIC_NARR];
    logic [FEIC_NARR-1:0]       pe_q;
    logic [FEIC_NARR-1:0]       pe_d;
    logic [FEIC_NARR-1:0]       me_q;
    logic [FEIC_NARR-1:0]       me_d;
    feic_cmd_s [FEIC_NARR-1:0]  cmd_q;
    feic_cmd_s [FEIC_NARR-1:0]  cmd_d;
    logic [31:0]                key_q;
    logic [31:0]                key_d;
    logic [FEIC_IRQ_W-1:0]      stat_q;
    logic [FEIC_IRQ_W-1:0]      stat_d;
    logic [FEIC_IRQ_W-1:0]      mask_q;
    logic [FEIC_IRQ_W-1:0]      mask_d;
    logic [31:0]                prdata_q;
    logic                       pslverr_q;
    logic [31:0]                rd_word;
    logic                       rd_err;

    // ==================================================================
    // APB decode
    // ==================================================================
    logic [FEIC_NARR-1:0]       ctl_hit;
    logic [FEIC_NARR-1:0]       ctl_we;
    logic [FEIC_NARR-1:0]       busy;
    logic [FEIC_NARR-1:0]       erase_req;
    logic [FEIC_NARR-1:0]       key_ok;
    logic [FEIC_NARR-1:0]       done_ev;
    logic [FEIC_NARR-1:0]       want;
    logic [FEIC_NARR-1:0]       first;
    logic [FEIC_NARR-1:0]       start;
    logic [FEIC_NARR-1:0]       refuse;
    wire                        setup    = I_PSEL & ~I_PENABLE;
    wire                        wr_acc   = I_PSEL & I_PENABLE & I_PWRITE;
    wire                        key_hit  = I_PADDR == FEIC_ADDR_KEY;
    wire                        stat_hit = I_PADDR == FEIC_ADDR_IRQ_STAT;
    wire                        mask_hit = I_PADDR == FEIC_ADDR_IRQ_MASK;
    wire                        key_we   = wr_acc & key_hit;
    wire                        stat_we  = wr_acc & stat_hit;
    wire                        mask_we  = wr_acc & mask_hit;
    wire                        any_busy = |busy;

    assign ctl_hit[FEIC_PB1] = I_PADDR == FEIC_ADDR_PB1_CTL;
    assign ctl_hit[FEIC_DF]  = I_PADDR == FEIC_ADDR_DF_CTL;
    assign ctl_hit[FEIC_PB2] = I_PADDR == FEIC_ADDR_PB2_CTL;

    // ==================================================================
    // Arbitration: one cycle at a time, lowest array index first
    // ==================================================================
    assign want   = erase_req | I_WRITE_REQ;
    assign first  = want & (~want + FEIC_NARR'(1));
    assign start  = first & key_ok & {FEIC_NARR{~any_busy}};                     // RULE10
    assign refuse = want & ~start;

    // ==================================================================
    // Per-array sequencing
    // ==================================================================
    for (genvar g = 0; g < FEIC_NARR; g++) begin : g_arr
        assign ctl_we[g]    = wr_acc & ctl_hit[g];
        assign erase_req[g] = ctl_we[g] & (I_PWDATA[FEIC_PE_BIT] | I_PWDATA[FEIC_ME_BIT]);   // RULE3 RULE5 RULE6
        assign key_ok[g]    = key_q == FEIC_KEY[g];                               // RULE10
        assign busy[g]      = st_q[g] == FEIC_RUN;                                // RULE14
        assign done_ev[g]   = busy[g] & I_FLASH_DONE[g];
        assign st_d[g]      = start[g] ? FEIC_RUN : (done_ev[g] ? FEIC_IDLE : st_q[g]);   // RULE14
        assign psel_d[g]    = (ctl_we[g] & ~busy[g]) ? (I_PWDATA[FEIC_PSEL_W-1:0] & FEIC_PSEL_MASK[g])
                                                     : psel_q[g];                 // RULE3 RULE7
        assign pe_d[g]      = (start[g] & erase_req[g]) ? (I_PWDATA[FEIC_PE_BIT] & ~I_PWDATA[FEIC_ME_BIT])
                            : (done_ev[g] ? 1'b0 : pe_q[g]);                      // RULE3 RULE4
        assign me_d[g]      = (start[g] & erase_req[g]) ? I_PWDATA[FEIC_ME_BIT]
                            : (done_ev[g] ? 1'b0 : me_q[g]);                      // RULE5 RULE6
        assign cmd_d[g].valid = start[g];
        assign cmd_d[g].op    = ~start[g] ? cmd_q[g].op
                              : (~erase_req[g] ? FEIC_OP_WRITE
                              : (I_PWDATA[FEIC_ME_BIT] ? FEIC_OP_MASS : FEIC_OP_PAGE));
        assign cmd_d[g].page  = start[g] ? psel_d[g] : cmd_q[g].page;             // RULE3 RULE7
        assign ctl_rd[g]      = ctl_word(busy[g], pe_q[g], me_q[g], psel_q[g]);   // RULE1 RULE2
    end

    // ==================================================================
    // Key, interrupt status and mask
    // ==================================================================
    assign key_d  = key_we ? I_PWDATA : ((|done_ev) ? FEIC_KEY_RST : key_q);      // RULE11
    assign stat_d = (stat_q & ~(stat_we ? I_PWDATA[FEIC_IRQ_W-1:0] : FEIC_IRQ_RST))
                  | {refuse, done_ev};
    assign mask_d = mask_we ? I_PWDATA[FEIC_IRQ_W-1:0] : mask_q;

    // ==================================================================
    // Read mux
    // ==================================================================
    always_comb begin
        rd_word = '0;
        rd_err  = 1'b0;
        if (ctl_hit[FEIC_PB1]) begin
            rd_word = ctl_rd[FEIC_PB1];
        end else if (ctl_hit[FEIC_DF]) begin
            rd_word = ctl_rd[FEIC_DF];
        end else if (ctl_hit[FEIC_PB2]) begin
            rd_word = ctl_rd[FEIC_PB2];
        end else if (key_hit) begin
            rd_word = key_q;
        end else if (stat_hit) begin
            rd_word[FEIC_IRQ_W-1:0] = stat_q;
        end else if (mask_hit) begin
            rd_word[FEIC_IRQ_W-1:0] = mask_q;
        end else begin
            rd_err = 1'b1;
        end
    end

    // ==================================================================
    // Registers
    // ==================================================================
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            st_q   <= '{default: FEIC_IDLE};
            psel_q <= '{default: FEIC_PSEL_RST};                                  // RULE13
            pe_q   <= '0;                                                         // RULE13
            me_q   <= '0;
            cmd_q  <= '0;
        end else begin
            st_q   <= st_d;
            psel_q <= psel_d;
            pe_q   <= pe_d;
            me_q   <= me_d;
            cmd_q  <= cmd_d;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            key_q     <= FEIC_KEY_RST;
            stat_q    <= FEIC_IRQ_RST;
            mask_q    <= FEIC_IRQ_RST;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            key_q     <= key_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            prdata_q  <= setup ? rd_word : prdata_q;
            pslverr_q <= setup ? rd_err : pslverr_q;
        end
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    assign O_PREADY    = I_PSEL & I_PENABLE;
    assign O_PRDATA    = prdata_q;
    assign O_PSLVERR   = pslverr_q & O_PREADY;
    assign O_FLASH_CMD = cmd_q;
    assign O_BUSY      = busy;
    assign O_IRQ       = |(stat_q & mask_q);

    // ==================================================================
    // Assertions
    // ==================================================================
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    property p_pb1_busy_rise;
        $rose(busy[FEIC_PB1]) |-> $past(start[FEIC_PB1]) && O_FLASH_CMD[FEIC_PB1].valid
                                  && ctl_rd[FEIC_PB1][FEIC_BUSY_BIT];
    endproperty
    a_pb1_busy_rise: assert property (p_pb1_busy_rise) else $error("bank1 busy rose without start"); // RULE1

    property p_df_busy_hold;
        busy[FEIC_DF] && !I_FLASH_DONE[FEIC_DF] |=> busy[FEIC_DF] && ctl_rd[FEIC_DF][FEIC_BUSY_BIT];
    endproperty
    a_df_busy_hold: assert property (p_df_busy_hold) else $error("data flash busy dropped early"); // RULE2

    property p_pb1_page_cmd;
        start[FEIC_PB1] && erase_req[FEIC_PB1] && I_PWDATA[FEIC_PE_BIT] && !I_PWDATA[FEIC_ME_BIT]
        |=> O_FLASH_CMD[FEIC_PB1].op == FEIC_OP_PAGE && pe_q[FEIC_PB1]
            && O_FLASH_CMD[FEIC_PB1].page == ($past(I_PWDATA[FEIC_PSEL_W-1:0]) & FEIC_PSEL_MASK[FEIC_PB1]);
    endproperty
    a_pb1_page_cmd: assert property (p_pb1_page_cmd) else $error("bank1 page erase command wrong"); // RULE3

    property p_pb1_page_clear;
        done_ev[FEIC_PB1] |=> !pe_q[FEIC_PB1] && !busy[FEIC_PB1];
    endproperty
    a_pb1_page_clear: assert property (p_pb1_page_clear) else $error("bank1 page erase bit not cleared"); // RULE4

    property p_pb2_mass;
        start[FEIC_PB2] && erase_req[FEIC_PB2] && I_PWDATA[FEIC_ME_BIT]
        |=> me_q[FEIC_PB2] && busy[FEIC_PB2] && O_FLASH_CMD[FEIC_PB2].op == FEIC_OP_MASS;
    endproperty
    a_pb2_mass: assert property (p_pb2_mass) else $error("bank2 mass erase not started"); // RULE5

    property p_df_mass_clear;
        done_ev[FEIC_DF] && me_q[FEIC_DF] |=> !me_q[FEIC_DF];
    endproperty
    a_df_mass_clear: assert property (p_df_mass_clear) else $error("data flash mass bit not cleared"); // RULE6

    property p_df_page_sel;
        O_FLASH_CMD[FEIC_DF].valid |-> O_FLASH_CMD[FEIC_DF].page == psel_q[FEIC_DF];
    endproperty
    a_df_page_sel: assert property (p_df_page_sel) else $error("data flash page mismatch"); // RULE7

    property p_key_gate;
        $rose(busy[FEIC_PB2]) |-> $past(key_q) == FEIC_KEY_B;
    endproperty
    a_key_gate: assert property (p_key_gate) else $error("bank2 started without its key"); // RULE10

    property p_key_clear;
        (|done_ev) && !key_we |=> key_q == FEIC_KEY_RST;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("key not cleared after cycle"); // RULE11

    property p_reset_vals;
        $rose(I_RST_N) |-> pe_q == '0 && me_q == '0 && psel_q[FEIC_DF] == FEIC_PSEL_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("erase bits not zero after reset"); // RULE13

    property p_pb2_busy_end;
        $fell(busy[FEIC_PB2]) |-> $past(I_FLASH_DONE[FEIC_PB2]);
    endproperty
    a_pb2_busy_end: assert property (p_pb2_busy_end) else $error("bank2 busy fell before done"); // RULE14

    property p_pb2_busy_rise;
        $rose(busy[FEIC_PB2]) |-> O_FLASH_CMD[FEIC_PB2].valid && ctl_rd[FEIC_PB2][FEIC_BUSY_BIT];
    endproperty
    a_pb2_busy_rise: assert property (p_pb2_busy_rise) else $error("bank2 busy rose without start"); // RULE1

    property p_df_busy_rise;
        $rose(busy[FEIC_DF]) |-> O_FLASH_CMD[FEIC_DF].valid && ctl_rd[FEIC_DF][FEIC_BUSY_BIT];
    endproperty
    a_df_busy_rise: assert property (p_df_busy_rise) else $error("data flash busy rose without start"); // RULE2

    property p_pb1_key_gate;
        $rose(busy[FEIC_PB1]) |-> $past(key_q) == FEIC_KEY_A;
    endproperty
    a_pb1_key_gate: assert property (p_pb1_key_gate) else $error("bank1 started without its key"); // RULE10

    property p_df_key_gate;
        $rose(busy[FEIC_DF]) |-> $past(key_q) == FEIC_KEY_A;
    endproperty
    a_df_key_gate: assert property (p_df_key_gate) else $error("data flash started without its key"); // RULE10

    property p_df_refused;
        refuse[FEIC_DF] |=> stat_q[FEIC_REF_LSB + FEIC_DF] && !$rose(busy[FEIC_DF]);
    endproperty
    a_df_refused: assert property (p_df_refused) else $error("data flash refusal not flagged"); // RULE10

    property p_pb1_mass;
        start[FEIC_PB1] && erase_req[FEIC_PB1] && I_PWDATA[FEIC_ME_BIT]
        |=> me_q[FEIC_PB1] && !pe_q[FEIC_PB1] && O_FLASH_CMD[FEIC_PB1].op == FEIC_OP_MASS;
    endproperty
    a_pb1_mass: assert property (p_pb1_mass) else $error("bank1 mass erase not started"); // RULE5

    property p_df_page;
        start[FEIC_DF] && erase_req[FEIC_DF] && I_PWDATA[FEIC_PE_BIT] && !I_PWDATA[FEIC_ME_BIT]
        |=> pe_q[FEIC_DF]
            && O_FLASH_CMD[FEIC_DF].page == ($past(I_PWDATA[FEIC_PSEL_W-1:0]) & FEIC_PSEL_MASK[FEIC_DF]);
    endproperty
    a_df_page: assert property (p_df_page) else $error("data flash page erase command wrong"); // RULE7

    property p_df_page_clear;
        done_ev[FEIC_DF] |=> !pe_q[FEIC_DF] && !me_q[FEIC_DF] && !busy[FEIC_DF];
    endproperty
    a_df_page_clear: assert property (p_df_page_clear) else $error("data flash erase bit not cleared"); // RULE4

    property p_pb2_erase_clear;
        done_ev[FEIC_PB2] |=> !me_q[FEIC_PB2] && !pe_q[FEIC_PB2];
    endproperty
    a_pb2_erase_clear: assert property (p_pb2_erase_clear) else $error("bank2 erase bit not cleared"); // RULE5

    property p_pb1_busy_hold;
        busy[FEIC_PB1] && !I_FLASH_DONE[FEIC_PB1] |=> busy[FEIC_PB1];
    endproperty
    a_pb1_busy_hold: assert property (p_pb1_busy_hold) else $error("bank1 busy dropped early"); // RULE14

    property p_pb1_cmd_hold;
        busy[FEIC_PB1] && !O_FLASH_CMD[FEIC_PB1].valid
        |-> $stable(O_FLASH_CMD[FEIC_PB1].op) && $stable(O_FLASH_CMD[FEIC_PB1].page);
    endproperty
    a_pb1_cmd_hold: assert property (p_pb1_cmd_hold) else $error("bank1 command changed while busy"); // RULE3

    property p_df_write_start;
        O_FLASH_CMD[FEIC_DF].valid && O_FLASH_CMD[FEIC_DF].op == FEIC_OP_WRITE
        |-> busy[FEIC_DF] && $past(I_WRITE_REQ[FEIC_DF]);
    endproperty
    a_df_write_start: assert property (p_df_write_start) else $error("data flash write without request"); // RULE14

    c_pb1_page:  cover property (start[FEIC_PB1] && erase_req[FEIC_PB1] ##[1:50] done_ev[FEIC_PB1]);
    c_df_mass:   cover property (start[FEIC_DF] && I_PWDATA[FEIC_ME_BIT] ##[1:50] done_ev[FEIC_DF]);
    c_refused:   cover property (|refuse);
    c_irq:       cover property ($rose(O_IRQ));

endmodule

// *** design/feic_pkg.sv ***
// Package: constants and types of the flash erase interlock controller
package feic_pkg;
    // ==================================================================
    // Arrays: 0 = program bank 1, 1 = data flash, 2 = program bank 2
    // ==================================================================
    localparam int          FEIC_NARR          = 3;
    localparam int          FEIC_PB1           = 0;
    localparam int          FEIC_DF            = 1;
    localparam int          FEIC_PB2           = 2;

    // ==================================================================
    // Register byte addresses
    // ==================================================================
    localparam logic [31:0] FEIC_ADDR_PB1_CTL  = 32'hFFFFFE90;
    localparam logic [31:0] FEIC_ADDR_DF_CTL   = 32'hFFFFFE94;
    localparam logic [31:0] FEIC_ADDR_KEY      = 32'hFFFFFE98;
    localparam logic [31:0] FEIC_ADDR_PB2_CTL  = 32'hFFFFFE9C;
    localparam logic [31:0] FEIC_ADDR_IRQ_STAT = 32'hFFFFFEA0;
    localparam logic [31:0] FEIC_ADDR_IRQ_MASK = 32'hFFFFFEA4;

    // ==================================================================
    // Control register fields
    // ==================================================================
    localparam int          FEIC_BUSY_BIT      = 11;
    localparam int          FEIC_PE_BIT        = 9;
    localparam int          FEIC_ME_BIT        = 8;
    localparam int          FEIC_PSEL_W        = 6;
    localparam logic [5:0]  FEIC_PSEL_MASK [FEIC_NARR] = '{6'h1F, 6'h3F, 6'h1F};
    localparam logic [5:0]  FEIC_PSEL_RST      = 6'h00;

    // ==================================================================
    // Interlock keys
    // ==================================================================
    localparam logic [31:0] FEIC_KEY_A         = 32'h42DC157E;
    localparam logic [31:0] FEIC_KEY_B         = 32'h6C97D0C5;
    localparam logic [31:0] FEIC_KEY [FEIC_NARR] = '{FEIC_KEY_A, FEIC_KEY_A, FEIC_KEY_B};
    localparam logic [31:0] FEIC_KEY_RST       = 32'h00000000;

    // ==================================================================
    // Interrupt status and mask layout: done[2:0], refused[5:3]
    // ==================================================================
    localparam int          FEIC_IRQ_W         = 6;
    localparam int          FEIC_DONE_LSB      = 0;
    localparam int          FEIC_REF_LSB       = 3;
    localparam logic [5:0]  FEIC_IRQ_RST       = 6'h00;

    // ==================================================================
    // Types
    // ==================================================================
    typedef enum logic [1:0] {
        FEIC_IDLE = 2'b01,
        FEIC_RUN  = 2'b10
    } feic_state_e;

    typedef enum logic [1:0] {
        FEIC_OP_WRITE = 2'h0,
        FEIC_OP_PAGE  = 2'h1,
        FEIC_OP_MASS  = 2'h2
    } feic_op_e;

    typedef struct packed {
        logic                   valid;
        feic_op_e               op;
        logic [FEIC_PSEL_W-1:0] page;
    } feic_cmd_s;
endpackage

// *** testbench/feic_flash_model.sv ***
// Flash array model: answers every started cycle with a done pulse, unless i_lat is zero
`timescale 1ns/1ns
module feic_flash_model
    import feic_pkg::*;
(
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_n,
    input  wire feic_cmd_s [FEIC_NARR-1:0] i_cmd,
    input  wire logic [FEIC_NARR-1:0]      i_busy,
    input  wire logic [7:0]                i_lat,
    output logic      [FEIC_NARR-1:0]      o_done
);
    // ==================================================================
    // Per-array cycle timer, latency chosen by the bench
    // ==================================================================
    logic [7:0] cnt_q [FEIC_NARR];

    always_ff @(posedge i_clock) begin
        for (int i = 0; i < FEIC_NARR; i++) begin
            if (!i_rst_n) begin
                cnt_q[i]  <= 8'h00;
                o_done[i] <= 1'b0;
            end else if (i_cmd[i].valid) begin
                cnt_q[i]  <= i_lat;
                o_done[i] <= 1'b0;
            end else begin
                o_done[i] <= i_busy[i] && (cnt_q[i] == 8'h01);
                if (cnt_q[i] != 8'h00) begin
                    cnt_q[i] <= cnt_q[i] - 8'h01;
                end
            end
        end
    end
endmodule

// *** testbench/flash_erase_interlock_ctrl_tb_top.sv ***
// Testbench: register, erase, interlock and interrupt checks
`timescale 1ns/1ns
module flash_erase_interlock_ctrl_tb_top
    import feic_pkg::*;
;
    logic                      clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0]               paddr, pwdata, prdata, rd;
    logic [FEIC_NARR-1:0]      wr_req, done, busy;
    logic [7:0]                lat;
    logic                      er;
    feic_cmd_s [FEIC_NARR-1:0] cmd;
    int                        miscompares, check_count;

    feic_ctrl i_feic_ctrl (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_WRITE_REQ(wr_req), .I_FLASH_DONE(done), .O_FLASH_CMD(cmd),
        .O_BUSY(busy), .O_IRQ(irq));
    feic_flash_model i_feic_flash_model (.i_clock(clk), .i_rst_n(rst_n), .i_cmd(cmd), .i_busy(busy),
        .i_lat(lat), .o_done(done));

    // ==================================================================
    // Clock, shared tasks
    // ==================================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    task automatic wait_idle();
        while (busy !== 3'h0) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic t_reset();
        rdchk(FEIC_ADDR_PB1_CTL, 32'h00000000);
        rdchk(FEIC_ADDR_DF_CTL, 32'h00000000);
        rdchk(FEIC_ADDR_PB2_CTL, 32'h00000000);
        rdchk(FEIC_ADDR_KEY, 32'h00000000);
        apb(1'b0, 32'hFFFFFEB0, 32'h00000000);
        chk({31'h0, er}, 32'h00000001);
    endtask

    task automatic t_page_pb1();
        lat <= 8'h14;
        wr(FEIC_ADDR_IRQ_MASK, 32'h00000001);
        wr(FEIC_ADDR_KEY, FEIC_KEY_A);
        wr(FEIC_ADDR_PB1_CTL, 32'h0000021F);
        chk({29'h0, busy}, 32'h00000001);
        chk({30'h0, cmd[0].op}, 32'h00000001);
        chk({26'h0, cmd[0].page}, 32'h0000001F);
        rdchk(FEIC_ADDR_PB1_CTL, 32'h00000A1F);
        rdchk(FEIC_ADDR_KEY, FEIC_KEY_A);
        wait_idle();
        rdchk(FEIC_ADDR_PB1_CTL, 32'h0000001F);
        rdchk(FEIC_ADDR_KEY, 32'h00000000);
        chk({31'h0, irq}, 32'h00000001);
        rdchk(FEIC_ADDR_IRQ_STAT, 32'h00000001);
        wr(FEIC_ADDR_IRQ_STAT, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
    endtask

    task automatic t_mass_df();
        wr(FEIC_ADDR_KEY, FEIC_KEY_A);
        wr(FEIC_ADDR_DF_CTL, 32'h0000013F);
        chk({30'h0, cmd[1].op}, 32'h00000002);
        chk({26'h0, cmd[1].page}, 32'h0000003F);
        rdchk(FEIC_ADDR_DF_CTL, 32'h0000093F);
        wait_idle();
        rdchk(FEIC_ADDR_DF_CTL, 32'h0000003F);
        rdchk(FEIC_ADDR_KEY, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
    endtask

    task automatic t_pb2();
        lat <= 8'h01;
        wr(FEIC_ADDR_KEY, FEIC_KEY_A);
        wr(FEIC_ADDR_PB2_CTL, 32'h00000100);
        chk({29'h0, busy}, 32'h00000000);
        rdchk(FEIC_ADDR_PB2_CTL, 32'h00000000);
        rdchk(FEIC_ADDR_IRQ_STAT, 32'h00000022);
        wr(FEIC_ADDR_IRQ_STAT, 32'h0000003F);
        wr(FEIC_ADDR_KEY, FEIC_KEY_B);
        wr(FEIC_ADDR_PB2_CTL, 32'h00000100);
        chk({30'h0, cmd[2].op}, 32'h00000002);
        wait_idle();
        rdchk(FEIC_ADDR_PB2_CTL, 32'h00000000);
        rdchk(FEIC_ADDR_KEY, 32'h00000000);
    endtask

    task automatic t_write_req();
        wr_req <= 3'h2;
        @(posedge clk);
        wr_req <= 3'h0;
        #1;
        chk({29'h0, busy}, 32'h00000000);
        @(posedge clk);
        wr(FEIC_ADDR_KEY, FEIC_KEY_A);
        wr_req <= 3'h2;
        @(posedge clk);
        wr_req <= 3'h0;
        #1;
        chk({29'h0, busy}, 32'h00000002);
        chk({31'h0, cmd[1].valid}, 32'h00000001);
        chk({30'h0, cmd[1].op}, 32'h00000000);
        @(posedge clk);
        wait_idle();
        rdchk(FEIC_ADDR_KEY, 32'h00000000);
    endtask

    task automatic t_mass_pb1();
        lat <= 8'h14;
        wr(FEIC_ADDR_IRQ_STAT, 32'h0000003F);
        wr(FEIC_ADDR_KEY, FEIC_KEY_A);
        wr(FEIC_ADDR_PB1_CTL, 32'h00000300);
        chk({30'h0, cmd[0].op}, 32'h00000002);
        rdchk(FEIC_ADDR_PB1_CTL, 32'h00000900);
        wr_req <= 3'h2;
        @(posedge clk);
        wr_req <= 3'h0;
        wait_idle();
        rdchk(FEIC_ADDR_PB1_CTL, 32'h00000000);
        rdchk(FEIC_ADDR_IRQ_STAT, 32'h00000011);
    endtask

    task automatic t_page_df();
        wr(FEIC_ADDR_KEY, FEIC_KEY_A);
        wr(FEIC_ADDR_DF_CTL, 32'h00000225);
        chk({30'h0, cmd[1].op}, 32'h00000001);
        chk({26'h0, cmd[1].page}, 32'h00000025);
        rdchk(FEIC_ADDR_DF_CTL, 32'h00000A25);
        wait_idle();
        rdchk(FEIC_ADDR_DF_CTL, 32'h00000025);
        rdchk(FEIC_ADDR_KEY, 32'h00000000);
    endtask

    // ==================================================================
    // Main sequence and watchdog
    // ==================================================================
    initial begin
        miscompares = 0;
        check_count = 0;
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 32'h00000000;
        pwdata  = 32'h00000000;
        wr_req  = 3'h0;
        lat     = 8'h01;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_page_pb1();
        t_mass_df();
        t_pb2();
        t_write_req();
        t_mass_pb1();
        t_page_df();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule
